// *** hdl/elac_defines.vh ***
// Constants for the EEPROM lock and access-control block.
`ifndef ELAC_DEFINES_VH
`define ELAC_DEFINES_VH
// Command codes presented on CMD_OP.
`define ELAC_OP_PREAD 3'h0
`define ELAC_OP_PWRITE 3'h1
`define ELAC_OP_CWRITE 3'h2
`define ELAC_OP_HREAD 3'h3
`define ELAC_OP_LOCK 3'h4
`define ELAC_OP_SERIAL 3'h5
`define ELAC_OP_PWEXPORT 3'h6
`define ELAC_OP_COUNTER 3'h7
// Lock field encodings.
`define ELAC_LOCK_LOCKED 2'h3
`define ELAC_LOCK_CONF 2'h2
`define ELAC_LOCK_OPEN 2'h0
`define ELAC_LOCK_BYTE_LOCKED 8'hFF
// Address map.
`define ELAC_ADDR_HEAD_END 9'h030
`define ELAC_ADDR_KEY_LO 9'h010
`define ELAC_ADDR_KEY_HI 9'h01F
`define ELAC_ADDR_SERIAL_LO 9'h020
`define ELAC_ADDR_SERIAL_HI 9'h02E
`define ELAC_ADDR_LOCK 9'h02F
`define ELAC_ADDR_PW_LO 9'h030
`define ELAC_ADDR_PW_HI 9'h06F
`define ELAC_ADDR_CNT_LO 9'h070
`define ELAC_ADDR_CNT_HI 9'h0AF
`define ELAC_ADDR_RSTR_LO 9'h10C
`define ELAC_ADDR_RSTR_HI 9'h10F
`define ELAC_ADDR_RO_LO 9'h110
`define ELAC_ADDR_REGION_HI 9'h100
`define ELAC_RSTR_DATA 8'hFF
// Password configuration bits.
`define ELAC_PCFG_CLEAR 0
`define ELAC_PCFG_BIND 1
`define ELAC_PCFG_RSV_HI 3
`define ELAC_PCFG_RSV_LO 2
`define ELAC_PCFG_SEC_HI 7
`define ELAC_PCFG_SEC_LO 4
// Status error codes.
`define ELAC_ERR_OK 3'h0
`define ELAC_ERR_INVALID 3'h2
`define ELAC_NUM_COUNTERS 4
`endif

// *** hdl/elac_pwcheck.v ***
// Password export check against its configuration byte.
`timescale 1ns/10ps
`include "elac_defines.vh"
module elac_pwcheck (
  // Configuration byte and session state.
  input wire [7:0] cfg,
  input wire [3:0] session_secret,
  input wire session_valid,
  // Verdict.
  output wire cfg_bad,
  output wire allowed,
  output wire clear_out
);
  wire bind_on;

  // Reserved bits must be zero or the operand is unacceptable.
  assign cfg_bad = |cfg[`ELAC_PCFG_RSV_HI:`ELAC_PCFG_RSV_LO];
  assign bind_on = cfg[`ELAC_PCFG_BIND];
  // Bound passwords need a session computed with the named secret.
  assign allowed = !bind_on ||
    (session_valid && (session_secret == cfg[`ELAC_PCFG_SEC_HI:`ELAC_PCFG_SEC_LO]));
  assign clear_out = cfg[`ELAC_PCFG_CLEAR];
endmodule

// *** hdl/elac_region.v ***
// Address region decoder for the EEPROM map.
`timescale 1ns/10ps
`include "elac_defines.vh"
module elac_region (
  // Target address and bounds.
  input wire [8:0] addr,
  input wire [7:0] rw_bound,
  input wire [7:0] sec_bound,
  // Region flags.
  output wire in_head,
  output wire in_key,
  output wire in_serial,
  output wire in_lock,
  output wire in_pw,
  output wire in_cnt,
  output wire in_rstr,
  output wire in_ro,
  output wire in_rw,
  output wire in_secret
);
  wire [8:0] rw_base;
  wire [8:0] sec_base;

  // Region bases are 0x100 OR the bound byte; low secret bits are dropped.
  assign rw_base = `ELAC_ADDR_REGION_HI | {1'b0, rw_bound};
  assign sec_base = `ELAC_ADDR_REGION_HI | {1'b0, sec_bound[7:3], 3'h0};
  assign in_head = addr < `ELAC_ADDR_HEAD_END;
  assign in_key = (addr >= `ELAC_ADDR_KEY_LO) && (addr <= `ELAC_ADDR_KEY_HI);
  assign in_serial = (addr >= `ELAC_ADDR_SERIAL_LO) && (addr <= `ELAC_ADDR_SERIAL_HI);
  assign in_lock = addr == `ELAC_ADDR_LOCK;
  assign in_pw = (addr >= `ELAC_ADDR_PW_LO) && (addr <= `ELAC_ADDR_PW_HI);
  assign in_cnt = (addr >= `ELAC_ADDR_CNT_LO) && (addr <= `ELAC_ADDR_CNT_HI);
  assign in_rstr = (addr >= `ELAC_ADDR_RSTR_LO) && (addr <= `ELAC_ADDR_RSTR_HI);
  // Secrets take precedence over the general area they sit above.
  assign in_secret = addr >= sec_base;
  assign in_ro = (addr >= `ELAC_ADDR_RO_LO) && (addr < rw_base) && !in_secret;
  assign in_rw = (addr >= rw_base) && !in_secret;
endmodule

// *** hdl/elac_top.v ***
// EEPROM lock state and per-command access checker.
`timescale 1ns/10ps
`include "elac_defines.vh"
module elac_top #(
  parameter [7:0] SHIP_LOCK_BYTE = 8'h02
) (
  // Clock and reset.
  input wire MCLK,
  input wire NRST,
  // Command request from the command decoder.
  input wire CMD_VALID,
  input wire [2:0] CMD_OP,
  input wire [8:0] CMD_ADDR,
  input wire [7:0] CMD_WDATA,
  input wire [7:0] CMD_PW_CFG,
  // Loaded configuration and session state.
  input wire [7:0] RW_BOUND,
  input wire [7:0] SEC_BOUND,
  input wire STARTUP_DONE,
  input wire SESSION_VALID,
  input wire [3:0] SESSION_SECRET,
  // Check result.
  output reg CHK_DONE,
  output reg CHK_GRANT,
  output reg [2:0] CHK_ERROR,
  output reg CHK_DECRYPT,
  output reg CHK_FORCE_FF,
  output reg CHK_PW_CLEAR,
  // EEPROM access strobes.
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [8:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  // Lock state seen by the rest of the device.
  output wire [7:0] LOCK_BYTE,
  output wire [1:0] LOCK_FIELD
);
  // Lock byte register and its next value.
  reg [7:0] lock_q;
  reg [7:0] lock_d;

  // Verdict of the access check for the command on the bus.
  reg ok;
  reg is_read;
  reg is_write;
  reg [2:0] err;

  // Lock field decodes.
  wire locked;
  wire conf;

  // Region flags for the command address.
  wire in_head;
  wire in_key;
  wire in_serial;
  wire in_lock;
  wire in_pw;
  wire in_cnt;
  wire in_rstr;
  wire in_ro;
  wire in_rw;
  wire in_secret;

  // Password configuration verdict.
  wire pw_bad;
  wire pw_allowed;
  wire pw_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Command classes.

  // Commands that fetch a byte from the array when granted, except at restricted bytes.
  function op_reads;
    input [2:0] op;
    begin
      op_reads = (op == `ELAC_OP_PREAD) || (op == `ELAC_OP_HREAD);
    end
  endfunction

  // Commands that store a byte into the array when granted.
  function op_writes;
    input [2:0] op;
    begin
      op_writes = (op == `ELAC_OP_PWRITE) || (op == `ELAC_OP_CWRITE);
    end
  endfunction

  // The ciphered write is the only command whose data needs the key.
  function op_ciphered;
    input [2:0] op;
    begin
      op_ciphered = op == `ELAC_OP_CWRITE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Lock state.

  // The shipped byte holds the factory tag in bits 7:2 and the field below.
  assign LOCK_BYTE = lock_q;
  assign LOCK_FIELD = lock_q[1:0];
  // Field 11 is locked, 10 confidential, 00 open. Field 01 is never shipped;
  // it decodes as open, so such a part still acts as a plain EEPROM until locked.
  assign locked = lock_q[1:0] == `ELAC_LOCK_LOCKED;
  assign conf = lock_q[1:0] == `ELAC_LOCK_CONF;

  // Only the lock command alters the lock byte; no path exists from one
  // unlocked value to the other, so plain writes to it are always dropped.
  // Locking from confidential also drops the key tag, because the whole byte
  // is overwritten rather than only its two-bit field.
  always @* begin
    lock_d = lock_q;
    if (CMD_VALID && (CMD_OP == `ELAC_OP_LOCK) && !locked) begin
      lock_d = `ELAC_LOCK_BYTE_LOCKED;
    end
  end

  // The shipped value models the factory-programmed cell content.
  // Limitation: the cell is not fetched back from the array here, so a reset
  // returns to the shipped value; the device must keep the stored byte itself.
  always @(posedge MCLK) begin
    if (!NRST) begin
      lock_q <= SHIP_LOCK_BYTE;
    end else begin
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoders.

  // Region flags for the command address; the bound bytes are levels.
  elac_region u_region (
    .addr(CMD_ADDR),
    .rw_bound(RW_BOUND),
    .sec_bound(SEC_BOUND),
    .in_head(in_head),
    .in_key(in_key),
    .in_serial(in_serial),
    .in_lock(in_lock),
    .in_pw(in_pw),
    .in_cnt(in_cnt),
    .in_rstr(in_rstr),
    .in_ro(in_ro),
    .in_rw(in_rw),
    .in_secret(in_secret)
  );

  // Password export verdict from the configuration byte on the bus.
  elac_pwcheck u_pwcheck (
    .cfg(CMD_PW_CFG),
    .session_secret(SESSION_SECRET),
    .session_valid(SESSION_VALID),
    .cfg_bad(pw_bad),
    .allowed(pw_allowed),
    .clear_out(pw_clear)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access check.

  // Judged combinationally, then registered so the EEPROM strobe and the
  // verdict leave together and a refused command never reaches the array.
  // The checks run from general to specific so that the last one that applies
  // decides; restricted bytes therefore come last in each read branch.
  always @* begin
    ok = 1'b0;
    is_read = op_reads(CMD_OP);
    is_write = op_writes(CMD_OP);
    case (CMD_OP)
      `ELAC_OP_PREAD: begin
        // Confidential parts refuse plain read altogether.
        ok = !conf && !in_head && !in_secret;
        // Password slots and their configs go dark once the part is locked.
        if (in_pw && locked) begin
          ok = 1'b0;
        end
        // Locked user areas stay closed until the startup challenge is answered.
        if (locked && (in_ro || in_rw) && !STARTUP_DONE) begin
          ok = 1'b0;
        end
        // Restricted bytes answer 0xFF wherever plain read itself is allowed.
        if (in_rstr) begin
          ok = !conf;
        end
      end
      `ELAC_OP_HREAD: begin
        // Hashed read covers serial and counters while confidential.
        ok = conf && !in_secret;
        // Restricted bytes answer 0xFF, but only where hashed read is allowed.
        if (in_rstr) begin
          ok = conf;
        end
      end
      `ELAC_OP_PWRITE, `ELAC_OP_CWRITE: begin
        // Ciphered writes need the confidential field; plain writes are narrowed below.
        if (op_ciphered(CMD_OP)) begin
          ok = conf;
        end else begin
          ok = 1'b1;
        end
        // Factory cells and the lock byte are never plain targets.
        if (in_key || in_serial || in_lock || in_rstr) begin
          ok = 1'b0;
        end
        // Once locked, password, secret, read-only and counter bytes are closed to writes;
        if (locked && (in_pw || in_secret || in_ro || in_cnt)) begin
          ok = 1'b0;
        end
        // the user area stays writable but waits for the startup challenge response.
        if (locked && in_rw && !STARTUP_DONE) begin
          ok = 1'b0;
        end
      end
      `ELAC_OP_PWEXPORT: begin
        // Reserved config bits make the operand unacceptable.
        ok = !pw_bad && pw_allowed;
      end
      `ELAC_OP_SERIAL: begin
        // The serial is readable this way in every lock state.
        ok = 1'b1;
      end
      `ELAC_OP_COUNTER: begin
        // Counter access needs no session, so nothing is checked here.
        // Counter values live in the array but are reached by their own datapath.
        ok = 1'b1;
      end
      `ELAC_OP_LOCK: begin
        // A second lock command is refused so the caller sees code two.
        ok = !locked;
      end
      default: begin
        // Every code of the 3-bit field is decoded; this branch is a safety net.
        ok = 1'b0;
      end
    endcase
    // One error code covers both a refused command and a bad operand.
    err = ok ? `ELAC_ERR_OK : `ELAC_ERR_INVALID;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and EEPROM strobes.

  // Restricted bytes are served as 0xFF by the output path, never by the array.
  // The verdict and strobes are pulses for exactly one cycle after the command;
  // the error code, address and data hold until the next command is taken.
  // Registering costs a cycle of latency but keeps the array strobes glitch-free.
  always @(posedge MCLK) begin
    if (!NRST) begin
      // Nothing is pending after reset and the error code reads as OK.
      CHK_DONE <= 1'b0;
      CHK_GRANT <= 1'b0;
      CHK_ERROR <= `ELAC_ERR_OK;
      CHK_DECRYPT <= 1'b0;
      CHK_FORCE_FF <= 1'b0;
      CHK_PW_CLEAR <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_ADDR <= 9'h000;
      MEM_WDATA <= 8'h00;
    end else begin
      CHK_DONE <= CMD_VALID;
      CHK_GRANT <= CMD_VALID && ok;
      CHK_ERROR <= CMD_VALID ? err : CHK_ERROR;
      CHK_DECRYPT <= CMD_VALID && ok && op_ciphered(CMD_OP);
      CHK_FORCE_FF <= CMD_VALID && ok && is_read && in_rstr;
      CHK_PW_CLEAR <= CMD_VALID && ok && (CMD_OP == `ELAC_OP_PWEXPORT) && pw_clear;
      MEM_RD <= CMD_VALID && ok && is_read && !in_rstr;
      MEM_WR <= CMD_VALID && ok && is_write;
      // Address and data follow every command, granted or not.
      if (CMD_VALID) begin
        MEM_ADDR <= CMD_ADDR;
        MEM_WDATA <= CMD_WDATA;
      end
    end
  end
endmodule

// *** tb/elac_checker.sv ***
// Port-level assertions for the EEPROM lock and access checker.
`timescale 1ns/10ps
module elac_checker (
  // Clock and reset.
  input wire MCLK,
  input wire NRST,
  // Command side.
  input wire CMD_VALID,
  input wire [2:0] CMD_OP,
  input wire [8:0] CMD_ADDR,
  // Verdict and strobes.
  input wire CHK_DONE,
  input wire CHK_GRANT,
  input wire [2:0] CHK_ERROR,
  input wire CHK_FORCE_FF,
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [7:0] LOCK_BYTE,
  input wire [1:0] LOCK_FIELD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  // Every command gets exactly one verdict, and strobes never appear uncaused.
  a_done_follows: assert property (CMD_VALID |=> CHK_DONE)
    else $error("no verdict after command");
  a_no_stray: assert property (!CMD_VALID |=> !CHK_DONE && !MEM_RD && !MEM_WR)
    else $error("verdict or strobe without command");
  a_refuse_code: assert property (CHK_DONE && !CHK_GRANT
    |-> CHK_ERROR == 3'h2 && !MEM_RD && !MEM_WR)
    else $error("refusal without code two or with access");
  a_grant_clean: assert property (CHK_DONE && CHK_GRANT |-> CHK_ERROR == 3'h0)
    else $error("grant with error code");
  // Fixed address protections; the head and key ones hold whatever the lock state.
  a_head_noread: assert property (CMD_VALID && CMD_OP == 3'h0
    && CMD_ADDR < 9'h030 |=> !CHK_GRANT)
    else $error("plain read of head granted");
  a_key_nowrite: assert property (CMD_VALID && CMD_OP inside {3'h1, 3'h2}
    && CMD_ADDR inside {[9'h010:9'h02E]} |=> !MEM_WR)
    else $error("write reached key or serial");
  a_rstr_guard: assert property (CMD_VALID && CMD_OP == 3'h0 && LOCK_FIELD != 2'h2
    && CMD_ADDR inside {[9'h10C:9'h10F]} |=> CHK_FORCE_FF && !MEM_RD)
    else $error("restricted read not forced");
  a_pw_sealed: assert property (LOCK_FIELD == 2'h3 && CMD_VALID
    && CMD_OP inside {3'h0, 3'h1} && CMD_ADDR inside {[9'h030:9'h06F]} |=> !CHK_GRANT)
    else $error("locked password area accessed");
  // Command sets per lock state; the field at the taking edge decides.
  a_locked_ops: assert property (LOCK_FIELD == 2'h3 && CMD_VALID
    && CMD_OP inside {3'h2, 3'h3} |=> !CHK_GRANT)
    else $error("locked part took cipher or hash op");
  a_conf_noread: assert property (LOCK_FIELD == 2'h2 && CMD_VALID
    && CMD_OP == 3'h0 |=> !CHK_GRANT)
    else $error("confidential part took plain read");
  a_open_ops: assert property (LOCK_FIELD == 2'h0 && CMD_VALID
    && CMD_OP inside {3'h2, 3'h3} |=> !CHK_GRANT)
    else $error("open part took cipher or hash op");
  // The lock byte only ever moves to all ones, and only by a lock command.
  a_lock_moves: assert property ($changed(LOCK_BYTE) |-> LOCK_BYTE == 8'hFF
    && $past(CMD_VALID) && $past(CMD_OP) == 3'h4)
    else $error("lock byte changed wrongly");
  cover property (CMD_VALID && CMD_OP == 3'h4 ##1 CHK_GRANT);
  cover property (CHK_DONE && !CHK_GRANT);
  cover property (CHK_FORCE_FF);
endmodule
bind elac_top elac_checker u_chk (.MCLK(MCLK), .NRST(NRST), .CMD_VALID(CMD_VALID),
  .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CHK_DONE(CHK_DONE), .CHK_GRANT(CHK_GRANT),
  .CHK_ERROR(CHK_ERROR), .CHK_FORCE_FF(CHK_FORCE_FF), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
  .LOCK_BYTE(LOCK_BYTE), .LOCK_FIELD(LOCK_FIELD));

// *** tb/elac_host.sv ***
// Host-side command source feeding the access checker.
`timescale 1ns/10ps
module elac_host (
  // Clock.
  input wire mclk,
  // Command request.
  output reg cmd_valid,
  output reg [2:0] cmd_op,
  output reg [8:0] cmd_addr,
  output reg [7:0] cmd_wdata,
  output reg [7:0] cmd_pw_cfg
);
  initial begin
    cmd_valid = 1'b0;
    {cmd_op, cmd_addr, cmd_wdata, cmd_pw_cfg} = 28'h0;
  end
  // One-cycle request; operands are scrambled afterwards so stale values never look valid.
  task issue(input [2:0] op, input [8:0] a, input [7:0] wd, input [7:0] cfg);
    begin
      @(negedge mclk);
      cmd_valid = 1'b1;
      {cmd_op, cmd_addr, cmd_wdata, cmd_pw_cfg} = {op, a, wd, cfg};
      @(negedge mclk);
      cmd_valid = 1'b0;
      {cmd_op, cmd_addr, cmd_wdata, cmd_pw_cfg} = ~{cmd_op, cmd_addr, cmd_wdata, cmd_pw_cfg};
    end
  endtask
endmodule

// *** tb/elac_top_tb.sv ***
// Self-checking bench for the lock and access checker.
`timescale 1ns/10ps
module elac_top_tb;
  reg MCLK = 1'b0;
  reg NRST = 1'b0;
  reg [7:0] RW_BOUND = 8'h40;
  reg [7:0] SEC_BOUND = 8'hD0;
  reg STARTUP_DONE = 1'b1;
  reg SESSION_VALID = 1'b1;
  reg [3:0] SESSION_SECRET = 4'h3;
  wire CMD_VALID, CHK_DONE, CHK_GRANT, CHK_DECRYPT, CHK_FORCE_FF, CHK_PW_CLEAR, MEM_RD, MEM_WR;
  wire [2:0] CMD_OP, CHK_ERROR;
  wire [8:0] CMD_ADDR, MEM_ADDR;
  wire [7:0] CMD_WDATA, CMD_PW_CFG, MEM_WDATA, LOCK_BYTE;
  wire [1:0] LOCK_FIELD;
  wire OPEN_DONE, OPEN_GRANT;
  wire [2:0] OPEN_ERROR;
  wire [7:0] OPEN_LOCK_BYTE;
  integer errors = 0;
  integer n_tests = 0;
  always #5 MCLK = ~MCLK;
  elac_host u_host (.mclk(MCLK), .cmd_valid(CMD_VALID), .cmd_op(CMD_OP), .cmd_addr(CMD_ADDR),
    .cmd_wdata(CMD_WDATA), .cmd_pw_cfg(CMD_PW_CFG));
  elac_top u_elac_top (.MCLK(MCLK), .NRST(NRST), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA), .CMD_PW_CFG(CMD_PW_CFG), .RW_BOUND(RW_BOUND),
    .SEC_BOUND(SEC_BOUND), .STARTUP_DONE(STARTUP_DONE), .SESSION_VALID(SESSION_VALID),
    .SESSION_SECRET(SESSION_SECRET), .CHK_DONE(CHK_DONE), .CHK_GRANT(CHK_GRANT),
    .CHK_ERROR(CHK_ERROR), .CHK_DECRYPT(CHK_DECRYPT), .CHK_FORCE_FF(CHK_FORCE_FF),
    .CHK_PW_CLEAR(CHK_PW_CLEAR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .LOCK_BYTE(LOCK_BYTE), .LOCK_FIELD(LOCK_FIELD));
  // A second part shipped open sees the same commands.
  elac_top #(.SHIP_LOCK_BYTE(8'h00)) u_elac_top_open (.MCLK(MCLK), .NRST(NRST),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA),
    .CMD_PW_CFG(CMD_PW_CFG), .RW_BOUND(RW_BOUND), .SEC_BOUND(SEC_BOUND),
    .STARTUP_DONE(STARTUP_DONE), .SESSION_VALID(SESSION_VALID),
    .SESSION_SECRET(SESSION_SECRET), .CHK_DONE(OPEN_DONE), .CHK_GRANT(OPEN_GRANT),
    .CHK_ERROR(OPEN_ERROR), .CHK_DECRYPT(), .CHK_FORCE_FF(), .CHK_PW_CLEAR(), .MEM_RD(),
    .MEM_WR(), .MEM_ADDR(), .MEM_WDATA(), .LOCK_BYTE(OPEN_LOCK_BYTE), .LOCK_FIELD());
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count.
  task chk(input [8:0] got, input [8:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Issue one command and check its verdict, strobes and captured operands.
  task cmd(input [2:0] op, input [8:0] a, input [7:0] cfg, input g, input ff = 1'b0);
    begin
      u_host.issue(op, a, 8'h5A, cfg);
      chk({4'h0, CHK_DONE, CHK_GRANT, CHK_DECRYPT, CHK_FORCE_FF, CHK_PW_CLEAR},
        {4'h0, 1'b1, g, g && op == 3'h2, ff, g && op == 3'h6 && cfg[0]});
      chk({6'h0, CHK_ERROR}, g ? 9'h000 : 9'h002);
      chk({7'h0, MEM_RD, MEM_WR},
        {7'h0, g && (op == 3'h0 || op == 3'h3) && !ff, g && (op == 3'h1 || op == 3'h2)});
      chk(MEM_ADDR, a);
      chk({1'b0, MEM_WDATA}, 9'h05A);
    end
  endtask
  // Command seen by both parts; only the open part's verdict is judged here.
  task ocmd(input [2:0] op, input [8:0] a, input g);
    begin
      u_host.issue(op, a, 8'h5A, 8'h00);
      chk({5'h00, OPEN_DONE, OPEN_ERROR}, {5'h00, 1'b1, g ? 3'h0 : 3'h2});
      chk({8'h00, OPEN_GRANT}, {8'h00, g});
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Shipped confidential, then personalised, locked and probed.
  initial begin
    repeat (16) @(negedge MCLK);
    NRST = 1'b1;
    chk({1'b0, LOCK_BYTE}, 9'h002);
    chk({1'b0, OPEN_LOCK_BYTE}, 9'h000);
    ocmd(3'h0, 9'h180, 1'b1);
    ocmd(3'h3, 9'h180, 1'b0);
    ocmd(3'h2, 9'h180, 1'b0);
    ocmd(3'h1, 9'h180, 1'b1);
    ocmd(3'h0, 9'h02F, 1'b0);
    ocmd(3'h0, 9'h070, 1'b1);
    ocmd(3'h0, 9'h10C, 1'b1);
    cmd(3'h0, 9'h180, 8'h00, 1'b0);
    cmd(3'h0, 9'h10C, 8'h00, 1'b0);
    cmd(3'h3, 9'h10C, 8'h00, 1'b1, 1'b1);
    cmd(3'h3, 9'h180, 8'h00, 1'b1);
    cmd(3'h2, 9'h180, 8'h00, 1'b1);
    cmd(3'h1, 9'h180, 8'h00, 1'b1);
    cmd(3'h2, 9'h010, 8'h00, 1'b0);
    cmd(3'h1, 9'h020, 8'h00, 1'b0);
    cmd(3'h5, 9'h020, 8'h00, 1'b1);
    u_host.issue(3'h1, 9'h02F, 8'h00, 8'h00);
    chk({1'b0, LOCK_BYTE}, 9'h002);
    cmd(3'h1, 9'h070, 8'h00, 1'b1);
    cmd(3'h3, 9'h070, 8'h00, 1'b1);
    cmd(3'h6, 9'h030, 8'h01, 1'b1);
    cmd(3'h6, 9'h030, 8'h0C, 1'b0);
    cmd(3'h6, 9'h030, 8'h52, 1'b0);
    SESSION_SECRET = 4'h5;
    cmd(3'h6, 9'h030, 8'h53, 1'b1);
    cmd(3'h4, 9'h000, 8'h00, 1'b1);
    chk({1'b0, LOCK_BYTE}, 9'h0FF);
    chk({1'b0, OPEN_LOCK_BYTE}, 9'h0FF);
    cmd(3'h4, 9'h000, 8'h00, 1'b0);
    cmd(3'h0, 9'h02F, 8'h00, 1'b0);
    cmd(3'h2, 9'h180, 8'h00, 1'b0);
    cmd(3'h3, 9'h180, 8'h00, 1'b0);
    cmd(3'h3, 9'h10C, 8'h00, 1'b0);
    cmd(3'h0, 9'h180, 8'h00, 1'b1);
    cmd(3'h1, 9'h140, 8'h00, 1'b1);
    cmd(3'h1, 9'h13F, 8'h00, 1'b0);
    cmd(3'h0, 9'h110, 8'h00, 1'b1);
    cmd(3'h1, 9'h030, 8'h00, 1'b0);
    cmd(3'h0, 9'h06F, 8'h00, 1'b0);
    cmd(3'h0, 9'h10C, 8'h00, 1'b1, 1'b1);
    cmd(3'h1, 9'h10F, 8'h00, 1'b0);
    SEC_BOUND = 8'hD5;
    cmd(3'h0, 9'h1D0, 8'h00, 1'b0);
    cmd(3'h0, 9'h1CF, 8'h00, 1'b1);
    cmd(3'h1, 9'h1F8, 8'h00, 1'b0);
    SESSION_VALID = 1'b0;
    cmd(3'h7, 9'h070, 8'h00, 1'b1);
    cmd(3'h1, 9'h070, 8'h00, 1'b0);
    results;
  end
endmodule
